/* mpsc_line_model.sv */
// phone line and chipset wake side model
`timescale 1ns/1ps
module mpsc_line_model (
	input  wire logic pclk,
	input  wire logic ring_on,
	input  wire logic wake_request,
	output logic      ring_detect_line,
	output int        wake_count
);
	logic w_r = 1'b0;
	initial ring_detect_line = 1'b0;
	initial wake_count = 0;
	// ring line follows the sensed ring
	always @(posedge pclk) ring_detect_line <= ring_on;
	// chipset counts each rising wake as one event
	always @(posedge pclk) begin
		w_r <= wake_request;
		if (wake_request && !w_r) wake_count <= wake_count + 1;
	end
endmodule

/* mpsc_pkg.sv */
// package of constants and carrier types for the modem power state control block
// ==========================================
package mpsc_pkg;

	// ==========================================
	// register offsets
	localparam logic [11:0] ADDR_CTRL      = 12'h000;
	localparam logic [11:0] ADDR_STATE     = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT  = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK  = 12'h00C;
	localparam logic [11:0] ADDR_RING_CNT  = 12'h010;

	// ==========================================
	// field positions
	localparam int CTRL_LOWPWR_BIT = 0;
	localparam int CTRL_OFF_BIT    = 1;
	localparam int CTRL_AUXEN_BIT  = 2;
	localparam int CTRL_WAKEEN_BIT = 3;
	localparam int CTRL_ANSWER_BIT = 4;
	localparam int CTRL_HOOK_BIT   = 5;

	localparam int IRQ_RING_BIT    = 0;
	localparam int IRQ_CHANGE_BIT  = 1;
	localparam int IRQ_WAKE_BIT    = 2;
	localparam int IRQ_W           = 3;

	// ==========================================
	// reset values
	localparam logic [31:0]      CTRL_RST = 32'h0000_0006;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

	// ==========================================
	// power state encoding equals state number
	typedef enum logic [1:0] {
		MPSC_D0 = 2'h0,
		MPSC_D1 = 2'h1,
		MPSC_D2 = 2'h2,
		MPSC_D3 = 2'h3
	} mpsc_pstate_t;

	// sequencer states, gray from ON through ISO to LOW; the ISO to OFF step flips both bits
	typedef enum logic [1:0] {
		SEQ_ON   = 2'h0,
		SEQ_ISO  = 2'h1,
		SEQ_LOW  = 2'h3,
		SEQ_OFF  = 2'h2
	} mpsc_seq_t;

	// ==========================================
	// timing: isolation settle before plane change
	localparam int    CLK_HZ     = 25_000_000;
	localparam int    ISO_SET_NS = 200;
	localparam int    ISO_CYC    = (ISO_SET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// ==========================================
	// carrier types
	typedef struct packed {
		logic controller_on;
		logic controller_low;
		logic context_kept;
		logic phone_on;
		logic phone_low;
		logic speaker_on;
		logic off_hook;
	} mpsc_func_t;

	typedef struct packed {
		logic main_power_plane;
		logic auxiliary_power_plane;
		logic main_iso_n;
		logic aux_iso_n;
	} mpsc_plane_t;

endpackage

/* mpsc_ring_det.sv */
// ring detect edge catcher with wake gating
`timescale 1ns/1ps
module mpsc_ring_det (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ring_detect_line,
	input  wire logic wake_enable,
	output logic      ring_pulse,
	output logic      wake_request
);

	// ==========================================
	// state
	typedef struct packed {
		logic ring_d;
		logic pulse;
		logic wake;
	} mpsc_rd_st_t;

	mpsc_rd_st_t st_r;
	mpsc_rd_st_t st_nxt;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.ring_d = ring_detect_line;
		st_nxt.pulse  = ring_detect_line & ~st_r.ring_d;
		// no plane gating: ring wake works in any power state
		st_nxt.wake   = ring_detect_line & wake_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ring_pulse   = st_r.pulse;
	assign wake_request = st_r.wake;

endmodule

/* mpsc_top.sv */
// modem power state control with apb registers
`timescale 1ns/1ps
module mpsc_top #(
	parameter int ISO_CYCLES = mpsc_pkg::ISO_CYC
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   ring_detect_line,
	input  wire logic                   dial_request,
	output logic                        wake_request,
	output logic                        irq,
	output logic                        modem_low_power_request,
	output logic                        modem_off_request,
	output logic                        auxiliary_plane_enable,
	output mpsc_pkg::mpsc_plane_t       planes,
	output mpsc_pkg::mpsc_func_t        func,
	output mpsc_pkg::mpsc_pstate_t      power_state
);

	// ==========================================
	// state
	typedef struct packed {
		logic [5:0]                  ctrl;
		logic [mpsc_pkg::IRQ_W-1:0]  stat;
		logic [mpsc_pkg::IRQ_W-1:0]  mask;
		logic [15:0]                 ring_cnt;
		mpsc_pkg::mpsc_seq_t         seq;
		logic [7:0]                  tmr;
		mpsc_pkg::mpsc_pstate_t      pst;
		mpsc_pkg::mpsc_plane_t       pl;
		mpsc_pkg::mpsc_func_t        fn;
		logic [31:0]                 rdata;
	} mpsc_st_t;

	mpsc_st_t st_r;
	mpsc_st_t st_nxt;

	logic ring_pulse;
	logic wake_int;

	mpsc_ring_det u_ring (
		.pclk             (pclk),
		.presetn          (presetn),
		.ring_detect_line (ring_detect_line),
		.wake_enable      (st_r.ctrl[mpsc_pkg::CTRL_WAKEEN_BIT]),
		.ring_pulse       (ring_pulse),
		.wake_request     (wake_int)
	);

	// requested target from control bits; off wins over low
	function automatic mpsc_pkg::mpsc_seq_t target(input logic [5:0] c);
		if (c[mpsc_pkg::CTRL_OFF_BIT]) begin
			target = mpsc_pkg::SEQ_OFF;
		end else if (c[mpsc_pkg::CTRL_LOWPWR_BIT]) begin
			target = mpsc_pkg::SEQ_LOW;
		end else begin
			target = mpsc_pkg::SEQ_ON;
		end
	endfunction

	function automatic logic [7:0] iso_len();
		iso_len = 8'(ISO_CYCLES);
	endfunction

	localparam int IRQ_W_L = mpsc_pkg::IRQ_W;
	logic                 acc;
	logic                 wr;
	logic [IRQ_W_L-1:0]   ev;
	mpsc_pkg::mpsc_seq_t  tgt;

	assign acc = psel & penable;
	assign wr  = acc & pwrite;
	assign tgt = target(st_r.ctrl);

	always_comb begin
		st_nxt = st_r;
		ev     = '0;

		// ==========================================
		// register writes
		if (wr) begin
			if (paddr == mpsc_pkg::ADDR_CTRL) begin
				st_nxt.ctrl = pwdata[5:0];
			end else if (paddr == mpsc_pkg::ADDR_IRQ_MASK) begin
				st_nxt.mask = pwdata[IRQ_W_L-1:0];
			end
		end

		// ==========================================
		// power sequencer: isolate before removing planes; on return to ON release both isolations, aux even with its plane disabled
		case (st_r.seq)
			mpsc_pkg::SEQ_ON: begin
				if (tgt != mpsc_pkg::SEQ_ON) begin
					st_nxt.pl.aux_iso_n = 1'b0;
					if (tgt == mpsc_pkg::SEQ_OFF) begin
						st_nxt.pl.main_iso_n = 1'b0;
					end
					st_nxt.tmr = iso_len();
					st_nxt.seq = mpsc_pkg::SEQ_ISO;
				end
			end
			mpsc_pkg::SEQ_ISO: begin
				if (st_r.tmr != 8'h00) begin
					st_nxt.tmr = st_r.tmr - 8'h01;
				end else if (tgt == mpsc_pkg::SEQ_OFF) begin
					st_nxt.seq = mpsc_pkg::SEQ_OFF;
				end else if (tgt == mpsc_pkg::SEQ_LOW) begin
					st_nxt.seq = mpsc_pkg::SEQ_LOW;
				end else begin
					// powering up: main plane is on, aux plane only if enabled, now release isolation
					st_nxt.pl.aux_iso_n  = 1'b1;
					st_nxt.pl.main_iso_n = 1'b1;
					st_nxt.seq           = mpsc_pkg::SEQ_ON;
				end
			end
			mpsc_pkg::SEQ_LOW: begin
				if (tgt != mpsc_pkg::SEQ_LOW) begin
					if (tgt == mpsc_pkg::SEQ_OFF) begin
						st_nxt.pl.main_iso_n = 1'b0;
					end
					st_nxt.tmr = iso_len();
					st_nxt.seq = mpsc_pkg::SEQ_ISO;
				end
			end
			default: begin
				if (tgt != mpsc_pkg::SEQ_OFF) begin
					st_nxt.tmr = iso_len();
					st_nxt.seq = mpsc_pkg::SEQ_ISO;
				end
			end
		endcase

		// ==========================================
		// power state per sequencer state; ISO keeps the previous one
		case (st_nxt.seq)
			mpsc_pkg::SEQ_ON: begin
				st_nxt.pst = mpsc_pkg::MPSC_D0;
			end
			mpsc_pkg::SEQ_LOW: begin
				st_nxt.pst = mpsc_pkg::MPSC_D1;
			end
			mpsc_pkg::SEQ_OFF: begin
				st_nxt.pst = mpsc_pkg::MPSC_D3;
			end
			default: begin
				st_nxt.pst = st_r.pst;
			end
		endcase
		// planes stay up while isolation settles; clearing aux enable in ON, or a switch to off during ISO, removes a plane still de-isolated
		st_nxt.pl.main_power_plane      = (tgt != mpsc_pkg::SEQ_OFF) |
			(st_nxt.seq == mpsc_pkg::SEQ_ISO && st_nxt.tmr != 8'h00 && st_r.pst != mpsc_pkg::MPSC_D3);
		st_nxt.pl.auxiliary_power_plane = (st_r.ctrl[mpsc_pkg::CTRL_AUXEN_BIT] & (tgt == mpsc_pkg::SEQ_ON)) |
			(st_nxt.seq == mpsc_pkg::SEQ_ISO && st_nxt.tmr != 8'h00 && st_r.pst == mpsc_pkg::MPSC_D0 &&
			st_r.pl.auxiliary_power_plane);

		// ==========================================
		// functional enables per state
		st_nxt.fn = '0;
		case (st_nxt.pst)
			mpsc_pkg::MPSC_D0: begin
				st_nxt.fn.controller_on = 1'b1;
				st_nxt.fn.context_kept  = 1'b1;
				st_nxt.fn.phone_on      = 1'b1;
				st_nxt.fn.speaker_on    = 1'b1;
				st_nxt.fn.off_hook      = st_r.ctrl[mpsc_pkg::CTRL_HOOK_BIT];
			end
			mpsc_pkg::MPSC_D1: begin
				st_nxt.fn.controller_on  = 1'b1;
				st_nxt.fn.controller_low = 1'b1;
				st_nxt.fn.context_kept   = 1'b1;
				st_nxt.fn.phone_low      = 1'b1;
			end
			default: begin
				// controller off, context lost, phone on line power, on hook
				st_nxt.fn = '0;
			end
		endcase

		// ==========================================
		// events: ring, state change, wake
		ev[mpsc_pkg::IRQ_RING_BIT]   = ring_pulse;
		ev[mpsc_pkg::IRQ_CHANGE_BIT] = (st_nxt.pst != st_r.pst);
		ev[mpsc_pkg::IRQ_WAKE_BIT]   = ring_pulse & st_r.ctrl[mpsc_pkg::CTRL_WAKEEN_BIT];
		if (wr && paddr == mpsc_pkg::ADDR_IRQ_STAT) begin
			st_nxt.stat = st_r.stat & ~pwdata[IRQ_W_L-1:0];
		end
		st_nxt.stat = st_nxt.stat | ev;
		if (ring_pulse) begin
			st_nxt.ring_cnt = st_r.ring_cnt + 16'h0001;
		end

		// ==========================================
		// read data
		st_nxt.rdata = st_r.rdata;
		if (acc && !pwrite) begin
			if (paddr == mpsc_pkg::ADDR_CTRL) begin
				st_nxt.rdata = {26'h0, st_r.ctrl};
			end else if (paddr == mpsc_pkg::ADDR_STATE) begin
				st_nxt.rdata = {24'h0, st_r.seq, st_r.pl, st_r.pst};
			end else if (paddr == mpsc_pkg::ADDR_IRQ_STAT) begin
				st_nxt.rdata = {29'h0, st_r.stat};
			end else if (paddr == mpsc_pkg::ADDR_IRQ_MASK) begin
				st_nxt.rdata = {29'h0, st_r.mask};
			end else if (paddr == mpsc_pkg::ADDR_RING_CNT) begin
				st_nxt.rdata = {16'h0, st_r.ring_cnt};
			end else begin
				st_nxt.rdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r          <= '0;
			st_r.ctrl     <= mpsc_pkg::CTRL_RST[5:0];
			st_r.mask     <= mpsc_pkg::MASK_RST;
			st_r.seq      <= mpsc_pkg::SEQ_OFF;
			st_r.pst      <= mpsc_pkg::MPSC_D3;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// apb answer: one wait state on reads, none on writes
	logic rd_wait_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_wait_r <= 1'b0;
		end else begin
			rd_wait_r <= psel & penable & ~pwrite & ~rd_wait_r;
		end
	end

	assign pready  = pwrite | rd_wait_r;
	assign pslverr = 1'b0;
	assign prdata  = st_r.rdata;

	assign irq                     = |(st_r.stat & st_r.mask);
	assign wake_request            = wake_int;
	assign modem_low_power_request = (st_r.pst == mpsc_pkg::MPSC_D1);
	assign modem_off_request       = (st_r.pst == mpsc_pkg::MPSC_D3);
	assign auxiliary_plane_enable  = st_r.pl.auxiliary_power_plane;
	assign planes                  = st_r.pl;
	assign func                    = st_r.fn;
	assign power_state             = st_r.pst;

	logic unused_dial;
	assign unused_dial = dial_request;

endmodule

/* mpsc_top_asserts.sv */
// port assertions for the modem power state control block
`timescale 1ns/1ps
module mpsc_top_asserts (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic                   pready,
	input wire logic                   ring_detect_line,
	input wire logic                   wake_request,
	input wire logic                   modem_low_power_request,
	input wire logic                   modem_off_request,
	input wire logic                   auxiliary_plane_enable,
	input wire mpsc_pkg::mpsc_plane_t  planes,
	input wire mpsc_pkg::mpsc_func_t   func,
	input wire mpsc_pkg::mpsc_pstate_t power_state
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// read handshake
	sequence s_rd_req;
		psel && !penable && !pwrite ##1 psel && penable;
	endsequence
	sequence s_rd_ans;
		!pready ##1 pready;
	endsequence
	property p_rd_wait; s_rd_req |-> s_rd_ans; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	// ==========================================
	// state contents
	property p_d0; power_state == 2'h0 |-> func.controller_on && func.phone_on && func.speaker_on; endproperty
	a_d0: assert property (p_d0) else $error("full-on functions off");
	property p_d1;
		power_state == 2'h1 |-> modem_low_power_request && func.controller_low && func.context_kept
			&& !func.speaker_on && !func.off_hook;
	endproperty
	a_d1: assert property (p_d1) else $error("low-power state wrong");
	property p_d3;
		power_state == 2'h3 |-> modem_off_request && !func.controller_on && !func.context_kept
			&& !func.speaker_on && !func.off_hook;
	endproperty
	a_d3: assert property (p_d3) else $error("off state wrong");
	property p_enc; power_state != 2'h2; endproperty
	a_enc: assert property (p_enc) else $error("unused state code");
	property p_main_iso; planes.main_iso_n |-> planes.main_power_plane; endproperty
	a_main_iso: assert property (p_main_iso) else $error("main released without power");
	property p_aux_iso; planes.aux_iso_n |-> planes.auxiliary_power_plane; endproperty
	a_aux_iso: assert property (p_aux_iso) else $error("aux released without power");
	property p_auxen; auxiliary_plane_enable == planes.auxiliary_power_plane; endproperty
	a_auxen: assert property (p_auxen) else $error("aux enable differs from plane");
	property p_main_seq; $fell(planes.main_power_plane) |-> !$past(planes.main_iso_n); endproperty
	a_main_seq: assert property (p_main_seq) else $error("main removed before isolation");
	property p_aux_seq; $fell(planes.auxiliary_power_plane) |-> !$past(planes.aux_iso_n); endproperty
	a_aux_seq: assert property (p_aux_seq) else $error("aux removed before isolation");
	property p_wake; !ring_detect_line |=> !wake_request; endproperty
	a_wake: assert property (p_wake) else $error("wake without ring");
endmodule

bind mpsc_top mpsc_top_asserts mpsc_top_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .ring_detect_line(ring_detect_line),
	.wake_request(wake_request), .modem_low_power_request(modem_low_power_request),
	.modem_off_request(modem_off_request), .auxiliary_plane_enable(auxiliary_plane_enable),
	.planes(planes), .func(func), .power_state(power_state));

/* mpsc_top_tb.sv */
// self-checking testbench for the modem power state control block
`timescale 1ns/1ps
module mpsc_top_tb;
	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic [11:0]            paddr = 12'h000;
	logic [31:0]            pwdata = 32'h0;
	logic [31:0]            prdata, rd;
	logic                   pready, ring_on = 1'b0, dial = 1'b0;
	logic                   ring, wake, irq, lowreq, offreq, auxen;
	mpsc_pkg::mpsc_plane_t  planes;
	mpsc_pkg::mpsc_func_t   func;
	mpsc_pkg::mpsc_pstate_t pstate;
	int                     err_count = 0;
	int                     total_checks = 0;
	int                     wakes;

	always #20 pclk = ~pclk;

	mpsc_top #(.ISO_CYCLES(1)) mpsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
		.ring_detect_line(ring), .dial_request(dial), .wake_request(wake), .irq(irq),
		.modem_low_power_request(lowreq), .modem_off_request(offreq), .auxiliary_plane_enable(auxen),
		.planes(planes), .func(func), .power_state(pstate));
	mpsc_line_model mpsc_line_model_i (.pclk(pclk), .ring_on(ring_on), .wake_request(wake),
		.ring_detect_line(ring), .wake_count(wakes));

	// ==========================================
	// shared tasks
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// apb transfer; read data lands in rd
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		if (n >= 50) begin
			err_count++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge between transfers so no strobe is set twice in one step
		@(posedge pclk);
	endtask

	task automatic go(input logic [31:0] ctrl, input logic [1:0] st);
		int n = 0;
		xfer(1'b1, mpsc_pkg::ADDR_CTRL, ctrl);
		while (pstate !== st && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 40) begin
			err_count++;
			end_of_test();
		end
		chk(pstate, st);
		xfer(1'b0, mpsc_pkg::ADDR_STATE, 32'h0);
		chk(rd[1:0], st);
	endtask

	task automatic ring_wait(input logic we);
		int n = 0;
		ring_on <= 1'b1;
		while (irq !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 40) begin
			err_count++;
			end_of_test();
		end
		ring_on <= 1'b0;
		xfer(1'b0, mpsc_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd[2:0], {we, 2'b01});
		chk(wakes, we);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset;
		chk({pstate, offreq, planes.main_power_plane}, 4'hE);
		xfer(1'b0, mpsc_pkg::ADDR_CTRL, 32'h0);
		chk(rd, mpsc_pkg::CTRL_RST);
		xfer(1'b0, mpsc_pkg::ADDR_IRQ_MASK, 32'h0);
		chk(rd, mpsc_pkg::MASK_RST);
		xfer(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_states;
		go(32'h24, 2'h0);
		chk({func.controller_on, func.phone_on, func.speaker_on, func.off_hook}, 4'hF);
		chk({planes.main_power_plane, planes.auxiliary_power_plane, auxen}, 3'h7);
		go(32'h31, 2'h1);
		chk({lowreq, offreq, func.controller_low, func.context_kept, func.speaker_on, func.off_hook}, 6'h2C);
		chk({planes.main_power_plane, planes.auxiliary_power_plane}, 2'h2);
		dial <= 1'b1;
		go(32'h04, 2'h0);
		dial <= 1'b0;
		go(32'h02, 2'h3);
		chk({offreq, func}, 8'h80);
		chk({planes.main_power_plane, planes.auxiliary_power_plane}, 2'h0);
		$display("state test done");
	endtask

	task automatic t_ring;
		xfer(1'b1, mpsc_pkg::ADDR_IRQ_STAT, 32'h7);
		xfer(1'b1, mpsc_pkg::ADDR_IRQ_MASK, 32'h5);
		ring_wait(1'b0);
		xfer(1'b1, mpsc_pkg::ADDR_IRQ_STAT, 32'h1);
		chk(irq, 1'b0);
		go(32'h0A, 2'h3);
		ring_wait(1'b1);
		xfer(1'b0, mpsc_pkg::ADDR_RING_CNT, 32'h0);
		chk(rd, 32'h0000_0002);
		go(32'h0C, 2'h0);
		xfer(1'b1, mpsc_pkg::ADDR_IRQ_MASK, 32'h0);
		chk(irq, 1'b0);
		xfer(1'b1, mpsc_pkg::ADDR_IRQ_STAT, 32'h7);
		xfer(1'b0, mpsc_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h0);
		$display("ring test done");
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_states();
		t_ring();
		end_of_test();
	end
endmodule
